// File: src/cdc_cal_regs.vh
// Register offsets, field positions, reset values and constants of the
// converter calibration register block. Included by the design files.
`ifndef CDC_CAL_REGS_VH
`define CDC_CAL_REGS_VH

`define POS_DAC_ADDR        8'h0B
`define NEG_DAC_ADDR        8'h0C
`define CAP_OFF_HI_ADDR     8'h0D
`define CAP_OFF_LO_ADDR     8'h0E
`define CAP_GAIN_HI_ADDR    8'h0F
`define CAP_GAIN_LO_ADDR    8'h10
`define VOLTAGE_GAIN_COEFFICIENT_HI_ADDR   8'h11
`define VOLTAGE_GAIN_COEFFICIENT_LO_ADDR   8'h12
`define CTRL_ADDR           8'h13
`define RESULT_HI_ADDR      8'h14
`define RESULT_MID_ADDR     8'h15
`define RESULT_LO_ADDR      8'h16

`define DAC_ATTACH_BIT      7
`define DAC_RESET           8'h00
`define CAP_OFF_RESET       16'h8000
`define CTRL_RESET          8'h00

// Control register fields
`define CTRL_DIFF_BIT       0
`define CTRL_EXC1_EN_BIT    1
`define CTRL_EXC1_INV_BIT   2
`define CTRL_EXC2_EN_BIT    3
`define CTRL_EXC2_INV_BIT   4
`define CTRL_VOLT_BIT       5
`define CTRL_OFFCAL_BIT     6

`define MID_SCALE           24'h800000
`define OFF_SHIFT           7

`endif

// File: src/sinc3_filter.v
// Third-order decimating filter on a one-bit density stream.
// Assumes bit_in is synchronous to clk and sampled when bit_valid is high.
module sinc3_filter #(
    parameter DECIM = 256,
    parameter W     = 25
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Modulator stream
    input  wire         bit_in,
    input  wire         bit_valid,
    // Filtered word
    output reg  [W-1:0] data_r,
    output reg          data_valid_r
);

reg [W-1:0] int_r [0:2];
reg [W-1:0] dif_r [0:2];
reg [15:0]  cnt_r;
wire [W-1:0] d0 = int_r[2] - dif_r[0];
wire [W-1:0] d1 = d0 - dif_r[1];
wire [W-1:0] d2 = d1 - dif_r[2];
wire         dump = bit_valid && (cnt_r == DECIM[15:0] - 16'h0001);

////////////////////////////////////////////////////////////////////////
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        int_r[0]     <= {W{1'b0}};
        int_r[1]     <= {W{1'b0}};
        int_r[2]     <= {W{1'b0}};
        dif_r[0]     <= {W{1'b0}};
        dif_r[1]     <= {W{1'b0}};
        dif_r[2]     <= {W{1'b0}};
        cnt_r        <= 16'h0000;
        data_r       <= {W{1'b0}};
        data_valid_r <= 1'b0;
    end else begin
        data_valid_r <= 1'b0;
        if (bit_valid) begin
            int_r[0] <= int_r[0] + {{(W-1){1'b0}}, bit_in};
            int_r[1] <= int_r[1] + int_r[0];
            int_r[2] <= int_r[2] + int_r[1];
            cnt_r    <= dump ? 16'h0000 : cnt_r + 16'h0001;
        end
        if (dump) begin
            dif_r[0]     <= int_r[2];
            dif_r[1]     <= d0;
            dif_r[2]     <= d1;
            data_r       <= d2;
            data_valid_r <= 1'b1;
        end
    end
end

endmodule // sinc3_filter

// File: src/cdc_offset_balance_dac_calibration_regs.v
// Calibration and control registers of the capacitance converter, plus
// the filtered result scaling. The host reaches registers through a
// byte-wide address pointer port from the serial front end on clk.
//
// Operation
// - Negative DAC attaches when bit 7 set and the negative input is connected (differential, not voltage mode)
// - DAC codes are 7-bit, monotonic
// - Offset coefficient subtracted in capacitance mode only; resets to 0x8000
// - Offset calibration writes coefficient automatically, in capacitance mode only
// - Offset LSB under 32 aF, span 1 pF
// - Capacitive gain coefficient shared by channels
// - Separate voltage gain coefficient
// - Filter output scaled before reading
// - Third-order filter converts bit stream
// - Excitation outputs configured independently
// - Single-ended mode detaches negative input
// - Differential mode reports input difference
// - Positive DAC attaches when bit 7 set
`include "cdc_cal_regs.vh"
module cdc_offset_balance_dac_calibration_regs #(
    parameter DECIM          = 256,
    parameter CAP_GAIN_INIT  = 16'h4000,
    parameter VOLTAGE_GAIN_COEFFICIENT_INIT = 16'h4000
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_r,
    // Modulator stream, from analog core
    input  wire        mod_bit,
    input  wire        mod_valid,
    // Analog switch controls
    output reg         pos_dac_attach,
    output reg  [6:0]  pos_dac_code,
    output reg         neg_dac_attach,
    output reg  [6:0]  neg_dac_code,
    output reg         neg_input_connect,
    output reg         excitation_out_first,
    output reg         excitation_out_second,
    output reg         excitation_first_inv,
    output reg         excitation_second_inv,
    // Result ready
    output reg         result_ready_r
);

reg  [7:0]  pos_dac_r;
reg  [7:0]  neg_dac_r;
reg  [15:0] cap_off_r;
reg  [15:0] cap_gain_r;
reg  [15:0] voltage_gain_coefficient_r;
reg  [7:0]  ctrl_r;
reg  [23:0] result_r;
reg  [15:0] lo_hold_r;

wire [24:0] filt_data;
wire        filt_valid;

////////////////////////////////////////////////////////////////////////
// third-order filter
sinc3_filter #(.DECIM(DECIM), .W(25)) u_filter (
    .clk          (clk),
    .rst_n        (rst_n),
    .bit_in       (mod_bit),
    .bit_valid    (mod_valid),
    .data_r       (filt_data),
    .data_valid_r (filt_valid)
);

////////////////////////////////////////////////////////////////////////
// offset then gain scaling of filter output
wire        volt_mode = ctrl_r[`CTRL_VOLT_BIT];
wire        offcal    = ctrl_r[`CTRL_OFFCAL_BIT];
wire [23:0] raw       = filt_data[24:1];
// offset subtract, coefficient LSB weighted by shift
wire signed [25:0] off_term =
    $signed({3'b000, cap_off_r, 7'h00}) - $signed({2'b00, 24'h800000});
wire signed [25:0] centred =
    $signed({2'b00, raw}) - $signed({2'b00, `MID_SCALE})
    - (volt_mode ? 26'sh0 : off_term);
wire [15:0] gain = volt_mode ? voltage_gain_coefficient_r : cap_gain_r;
wire signed [42:0] prod = centred * $signed({1'b0, gain});
wire signed [28:0] scaled = prod[42:14];
wire [23:0] sat = (scaled > 29'sh07FFFFF) ? 24'hFFFFFF :
                  (scaled < -29'sh0800000) ? 24'h000000 :
                  scaled[23:0] + `MID_SCALE;
// new zero-scale coefficient from raw reading
wire [15:0] new_off = raw[23:8] - 16'h8000 + cap_off_r;

////////////////////////////////////////////////////////////////////////
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        pos_dac_r      <= `DAC_RESET;
        neg_dac_r      <= `DAC_RESET;
        cap_off_r      <= `CAP_OFF_RESET;
        cap_gain_r     <= CAP_GAIN_INIT;
        voltage_gain_coefficient_r    <= VOLTAGE_GAIN_COEFFICIENT_INIT;
        ctrl_r         <= `CTRL_RESET;
        result_r       <= `MID_SCALE;
        result_ready_r <= 1'b0;
    end else begin
        if (reg_wr) begin
            case (reg_addr)
                `POS_DAC_ADDR:      pos_dac_r          <= reg_wdata;
                `NEG_DAC_ADDR:      neg_dac_r          <= reg_wdata;
                `CAP_OFF_HI_ADDR:   cap_off_r[15:8]    <= reg_wdata;
                `CAP_OFF_LO_ADDR:   cap_off_r[7:0]     <= reg_wdata;
                `CAP_GAIN_HI_ADDR:  cap_gain_r[15:8]   <= reg_wdata;
                `CAP_GAIN_LO_ADDR:  cap_gain_r[7:0]    <= reg_wdata;
                `VOLTAGE_GAIN_COEFFICIENT_HI_ADDR: voltage_gain_coefficient_r[15:8]  <= reg_wdata;
                `VOLTAGE_GAIN_COEFFICIENT_LO_ADDR: voltage_gain_coefficient_r[7:0]   <= reg_wdata;
                `CTRL_ADDR:         ctrl_r             <= reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd && reg_addr == `RESULT_HI_ADDR)
            result_ready_r <= 1'b0;
        if (filt_valid) begin
            // calibration result wins over a host write
            if (offcal && !volt_mode) begin
                cap_off_r <= new_off;
                ctrl_r[`CTRL_OFFCAL_BIT] <= 1'b0;
            end else begin
                result_r       <= sat;
                result_ready_r <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read mux; low result bytes frozen at high-byte read
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata_r <= 8'h00;
        lo_hold_r   <= 16'h0000;
    end else if (reg_rd) begin
        case (reg_addr)
            `POS_DAC_ADDR:      reg_rdata_r <= pos_dac_r;
            `NEG_DAC_ADDR:      reg_rdata_r <= neg_dac_r;
            `CAP_OFF_HI_ADDR:   reg_rdata_r <= cap_off_r[15:8];
            `CAP_OFF_LO_ADDR:   reg_rdata_r <= cap_off_r[7:0];
            `CAP_GAIN_HI_ADDR:  reg_rdata_r <= cap_gain_r[15:8];
            `CAP_GAIN_LO_ADDR:  reg_rdata_r <= cap_gain_r[7:0];
            `VOLTAGE_GAIN_COEFFICIENT_HI_ADDR: reg_rdata_r <= voltage_gain_coefficient_r[15:8];
            `VOLTAGE_GAIN_COEFFICIENT_LO_ADDR: reg_rdata_r <= voltage_gain_coefficient_r[7:0];
            `CTRL_ADDR:         reg_rdata_r <= ctrl_r;
            `RESULT_HI_ADDR:    reg_rdata_r <= result_r[23:16];
            `RESULT_MID_ADDR:   reg_rdata_r <= lo_hold_r[15:8];
            `RESULT_LO_ADDR:    reg_rdata_r <= lo_hold_r[7:0];
            default:            reg_rdata_r <= 8'h00;
        endcase
        if (reg_addr == `RESULT_HI_ADDR)
            lo_hold_r <= result_r[15:0];
    end
end

////////////////////////////////////////////////////////////////////////
// Analog switch decode
always @* begin
    pos_dac_attach        = pos_dac_r[`DAC_ATTACH_BIT];
    pos_dac_code          = pos_dac_r[6:0];
    // negative input only used in differential mode
    neg_input_connect     = ctrl_r[`CTRL_DIFF_BIT] && !volt_mode;
    // negative DAC attach follows bit 7 only while the negative input is connected
    neg_dac_attach        = neg_dac_r[`DAC_ATTACH_BIT] && neg_input_connect;
    neg_dac_code          = neg_dac_r[6:0];
    excitation_out_first  = ctrl_r[`CTRL_EXC1_EN_BIT];
    excitation_out_second = ctrl_r[`CTRL_EXC2_EN_BIT];
    excitation_first_inv  = ctrl_r[`CTRL_EXC1_INV_BIT];
    excitation_second_inv = ctrl_r[`CTRL_EXC2_INV_BIT];
end

endmodule // cdc_offset_balance_dac_calibration_regs

// File: tb/cdc_cal_chk.sv
// Assertion checker on the calibration register block ports.
// Assumes one clk domain and async active-low rst_n.
`include "cdc_cal_regs.vh"
module cdc_cal_chk (
    // Clock, reset and register port
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_r,
    // Switch controls and status
    input wire logic       pos_dac_attach,
    input wire logic [6:0] pos_dac_code,
    input wire logic       neg_dac_attach,
    input wire logic [6:0] neg_dac_code,
    input wire logic       neg_input_connect,
    input wire logic       excitation_out_first,
    input wire logic       excitation_out_second,
    input wire logic       excitation_first_inv,
    input wire logic       excitation_second_inv,
    input wire logic       result_ready_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire ctrl_wr = reg_wr && reg_addr == `CTRL_ADDR;

    neg_dac_load_a: assert property (reg_wr && reg_addr == `NEG_DAC_ADDR |=>
        neg_dac_code == $past(reg_wdata[6:0]) && neg_dac_attach == ($past(reg_wdata[7])
        && neg_input_connect)) else $error("negative dac setup not applied");
    pos_dac_load_a: assert property (reg_wr && reg_addr == `POS_DAC_ADDR |=>
        {pos_dac_attach, pos_dac_code} == $past(reg_wdata)) else $error("positive dac setup");
    single_ended_a: assert property (ctrl_wr && !reg_wdata[0] |=>
        !neg_input_connect && !neg_dac_attach) else $error("negative input left attached");
    diff_connect_a: assert property (ctrl_wr && reg_wdata[0] && !reg_wdata[5] |=>
        neg_input_connect) else $error("negative input not attached");
    exc_fields_a: assert property (ctrl_wr |=>
        {excitation_second_inv, excitation_out_second, excitation_first_inv,
        excitation_out_first} == $past(reg_wdata[4:1])) else $error("excitation setup");
    dac_hold_a: assert property (!reg_wr |=>
        $stable(pos_dac_code) && $stable(neg_dac_code)) else $error("dac code moved");
    unmapped_read_a: assert property (reg_rd && reg_addr == 8'h20 |=>
        reg_rdata_r == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_r))
        else $error("read data moved without read");
    cover property (ctrl_wr && reg_wdata[0]);
    cover property (neg_dac_attach);
    cover property ($rose(result_ready_r));
endmodule // cdc_cal_chk

bind cdc_offset_balance_dac_calibration_regs cdc_cal_chk chk (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .pos_dac_attach(pos_dac_attach), .pos_dac_code(pos_dac_code),
    .neg_dac_attach(neg_dac_attach), .neg_dac_code(neg_dac_code),
    .neg_input_connect(neg_input_connect), .excitation_out_first(excitation_out_first),
    .excitation_out_second(excitation_out_second), .excitation_first_inv(excitation_first_inv),
    .excitation_second_inv(excitation_second_inv), .result_ready_r(result_ready_r));

// File: tb/host_model.sv
// Host controller model driving the byte-wide register pointer port.
// Assumes the block samples strobes on the rising edge of clk.
module host_model (
    // Register port
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata_r
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    end
    // Idle bus shows inverted values so stale data is never mistaken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        {reg_addr, reg_rd} <= {~a, 1'b0};
        @(posedge clk);
        d = reg_rdata_r;
    endtask
endmodule // host_model

// File: tb/tb_top.sv
// Self-checking bench for the calibration register block.
// Assumes src/ on the include path; host_model drives the register port.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, mod_valid, reg_wr, reg_rd, pa, na, nic, x1, x2, i1, i2, rdy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r, a, d, m [0:31];
    logic [6:0] pc, nc;
    int         miscompares, n_tests, cycles;
    longint     o, g, e;
    cdc_offset_balance_dac_calibration_regs #(.DECIM(8)) dut (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .mod_bit(1'b0), .mod_valid(mod_valid),
        .pos_dac_attach(pa), .pos_dac_code(pc), .neg_dac_attach(na), .neg_dac_code(nc),
        .neg_input_connect(nic), .excitation_out_first(x1), .excitation_out_second(x2),
        .excitation_first_inv(i1), .excitation_second_inv(i2), .result_ready_r(rdy));
    host_model h (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [7:0] ex);
        logic [7:0] v;
        h.rd(ad, v);
        chk(v, ex);
    endtask
    // Zero-density stream: filter output is zero, result follows coefficients only
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            mod_valid <= ~mod_valid;
            if (rdy === 1'b1) break;
        end
        @(posedge clk);
        mod_valid <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {rst_n, mod_valid} = 2'b00;
        void'($urandom(42528));
        foreach (m[i]) m[i] = 8'h00;
        {m[13], m[15], m[17], m[20]} = {8'h80, 8'h40, 8'h40, 8'h80};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 11; k <= 22; k++) rdc(8'(k), m[k]);
        rdc(8'h20, 8'h00);
        h.wr(8'h14, 8'h55);
        rdc(8'h14, 8'h80);
        $display("test reset values done");
        repeat (40) begin
            a = 8'(11 + $urandom_range(8));
            d = 8'($urandom) & ((a == 8'h13) ? 8'hBF : 8'hFF);
            h.wr(a, d);
            m[a] = d;
            rdc(a, m[a]);
            chk(nic, m[19][0] && !m[19][5]);
            chk({pa, pc}, m[11]);
            chk({na, nc}, {m[12][7] && nic, m[12][6:0]});
            chk({i2, x2, i1, x1}, m[19][4:1]);
        end
        $display("test register and switch setup done");
        repeat (4) begin
            g = $urandom_range(32767);
            o = $urandom & 32'hFF80;
            {m[13], m[14], m[15], m[16]} = {o[15:0], g[15:0]};
            for (int k = 13; k <= 16; k++) h.wr(8'(k), m[k]);
            h.wr(8'h13, 8'h00);
            pulses(400);
            chk(rdy, 1'b1);
            e = 64'h800000 - o * g / 128;
            e = (e < 0) ? 0 : e;
            for (int k = 0; k < 3; k++) rdc(8'(20 + k), e[23 - 8 * k -: 8]);
        end
        $display("test scaled conversion done");
        h.wr(8'h0D, 8'h12);
        h.wr(8'h0E, 8'h34);
        h.wr(8'h13, 8'h40);
        pulses(40);
        rdc(8'h0D, 8'h92);
        rdc(8'h0E, 8'h34);
        rdc(8'h13, 8'h00);
        h.wr(8'h0D, 8'h5A);
        rdc(8'h0D, 8'h5A);
        h.wr(8'h0C, 8'h3A);
        rdc(8'h0C, 8'h3A);
        $display("test offset calibration done");
        report_and_stop();
    end
endmodule // tb_top
